//--- design/adcs_dev.sv
// converter end: command intake, result shift-out and power-down control
`include "adcs_cfg.svh"
module adcs_dev #(
  parameter int IDX = 0
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // link
  adcs_link_if.dev                       link,
  // user side
  input  wire logic [`ADCS_RES_BITS-1:0] conv_data,
  output logic      [`ADCS_CMD_BITS-1:0] conv_cfg,
  output logic                           conv_strobe,
  output logic                           powered_down,
  output logic                           system_off_output_n
);
  initial
  begin
    if (IDX < 0 || IDX >= $bits(link.cs_n)) $error("adcs_dev: IDX out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    adcs_pkg::adcs_dev_st_t          st;
    logic                            sclk_q;
    logic                            cs_q;
    logic [2:0]                      cnt;
    logic [`ADCS_CMD_BITS-1:0]       cmd;
    logic [`ADCS_OUT_BITS-1:0]       sh;
    logic                            dout;
    logic                            dout_oe;
    logic                            strobe;
    logic                            pd;
    logic                            sso_n;
  } adcs_dev_s_t;
  adcs_dev_s_t s;
  adcs_dev_s_t next_s;
  logic [`ADCS_RES_BITS-2:0] rev;
  logic                      cs_n;
  logic                      rise;
  logic                      fall;
  logic [`ADCS_CMD_BITS-1:0] cmd_full;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    for (int i = 0; i < `ADCS_RES_BITS - 1; i++)
    begin
      rev[i] = conv_data[`ADCS_RES_BITS - 1 - i];
    end
  end
  assign cs_n     = link.cs_n[IDX];
  assign rise     = link.sclk && !s.sclk_q;
  assign fall     = !link.sclk && s.sclk_q;
  assign cmd_full = {s.cmd[`ADCS_CMD_BITS-2:0], link.din_line};
  always_comb
  begin
    next_s        = s;
    next_s.sclk_q = link.sclk;
    next_s.cs_q   = cs_n;
    next_s.strobe = 1'b0;
    if (cs_n)
    begin
      next_s.st      = adcs_pkg::DEV_IDLE;
      next_s.dout_oe = 1'b0;
      next_s.dout    = 1'b0;
    end
    else
    begin
      if (s.cs_q)
      begin
        next_s.pd    = 1'b0;
        next_s.sso_n = 1'b1;
      end
      case (s.st)
        adcs_pkg::DEV_IDLE:
        begin
          if (rise && link.din_line)
          begin
            next_s.st  = adcs_pkg::DEV_CMD;
            next_s.cnt = 3'h0;
          end
        end
        adcs_pkg::DEV_CMD:
        begin
          if (rise)
          begin
            next_s.cmd = cmd_full;
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == 3'(`ADCS_CMD_BITS - 1))
            begin
              next_s.st = adcs_pkg::DEV_OUT;
              if (!cmd_full[`ADCS_CMD_PS])
              begin
                next_s.pd    = 1'b1;
                next_s.sso_n = 1'b0;
                next_s.sh    = {1'b0, {`ADCS_RES_BITS{1'b1}}, {`ADCS_RES_BITS{1'b0}}};
              end
              else
              begin
                next_s.strobe = 1'b1;
                if (cmd_full[`ADCS_CMD_FIRST_BIT_ORDER_SELECT])
                begin
                  next_s.sh = {1'b0, conv_data, {`ADCS_RES_BITS{1'b0}}};
                end
                else
                begin
                  next_s.sh = {1'b0, conv_data, rev, 1'b0};
                end
              end
            end
          end
        end
        adcs_pkg::DEV_OUT:
        begin
          if (fall)
          begin
            next_s.dout_oe = 1'b1;
            next_s.dout    = s.sh[`ADCS_OUT_BITS-1];
            next_s.sh      = {s.sh[`ADCS_OUT_BITS-2:0], 1'b0};
          end
        end
        default:
        begin
          next_s.st = adcs_pkg::DEV_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s       <= '0;
      s.st    <= adcs_pkg::DEV_IDLE;
      s.cs_q  <= 1'b1;
      s.sso_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign link.dout           = s.dout;
  assign link.dout_oe        = s.dout_oe;
  assign conv_cfg            = s.cmd;
  assign conv_strobe         = s.strobe;
  assign powered_down        = s.pd;
  assign system_off_output_n = s.sso_n;
endmodule // adcs_dev

//--- design/adcs_host.sv
// host end: frames the command, reads the result in the last two of three bytes
`include "adcs_cfg.svh"
module adcs_host #(
  parameter int NDEV      = 1,
  parameter int SCLK_HALF = `ADCS_SCLK_HALF
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // link
  adcs_link_if.host                      link,
  // request
  input  wire logic                      req,
  input  wire logic [`ADCS_CMD_BITS-1:0] req_cmd,
  input  wire logic [7:0]                req_dev,
  // answer
  output logic                           busy,
  output logic                           done,
  output logic [7:0]                     result_hi,
  output logic [7:0]                     result_lo,
  output logic [`ADCS_RES_BITS-1:0]      result
);
  if (SCLK_HALF < 2 || SCLK_HALF > 255)
  begin : g_bad_half
    $error("adcs_host: SCLK_HALF must be 2..255");
  end
  if (NDEV < 1 || NDEV > 256)
  begin : g_bad_ndev
    $error("adcs_host: NDEV must be 1..256");
  end
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    adcs_pkg::adcs_hst_st_t          st;
    logic [7:0]                      tmr;
    logic [4:0]                      bit_n;
    logic [`ADCS_FRAME_BITS-1:0]     frame;
    logic [`ADCS_FRAME_BITS-1:0]     rx;
    logic                            shut;
    logic [NDEV-1:0]                 cs_n;
    logic                            sclk;
    logic                            din;
    logic                            din_oe;
    logic                            busy;
    logic                            done;
    logic [7:0]                      hi;
    logic [7:0]                      lo;
    logic [`ADCS_RES_BITS-1:0]       res;
  } adcs_hst_s_t;
  adcs_hst_s_t s;
  adcs_hst_s_t next_s;
  logic [`ADCS_FRAME_BITS-1:0] rx_next;
  logic                        tmr_end;
  ////////////////////////////////////////////////////////////////////////////
  assign tmr_end = (s.tmr == 8'(SCLK_HALF - 1));
  assign rx_next = {s.rx[`ADCS_FRAME_BITS-2:0], link.dout_line};
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    next_s.tmr  = tmr_end ? 8'h0 : s.tmr + 8'h1;
    case (s.st)
      adcs_pkg::HST_IDLE:
      begin
        next_s.tmr = 8'h0;
        if (req)
        begin
          next_s.st    = adcs_pkg::HST_SETUP;
          next_s.busy  = 1'b1;
          next_s.bit_n = 5'h0;
          // byte one: leading zeros, start bit, first command bits
          next_s.frame = {{`ADCS_LEAD_ZEROS{1'b0}}, 1'b1, req_cmd, 13'h0};
          next_s.shut  = !req_cmd[`ADCS_CMD_PS];
          next_s.rx    = '0;
          for (int i = 0; i < NDEV; i++)
          begin
            next_s.cs_n[i] = !(req_dev == 8'(i));
          end
          next_s.din_oe = 1'b1;
        end
      end
      adcs_pkg::HST_SETUP:
      begin
        if (tmr_end)
        begin
          next_s.st    = adcs_pkg::HST_LOW;
          next_s.din   = s.frame[`ADCS_FRAME_BITS-1];
          next_s.frame = {s.frame[`ADCS_FRAME_BITS-2:0], 1'b0};
        end
      end
      adcs_pkg::HST_LOW:
      begin
        if (tmr_end)
        begin
          next_s.st   = adcs_pkg::HST_HIGH;
          next_s.sclk = 1'b1;
          next_s.rx   = rx_next;
        end
      end
      adcs_pkg::HST_HIGH:
      begin
        if (tmr_end)
        begin
          next_s.sclk  = 1'b0;
          next_s.bit_n = s.bit_n + 5'h1;
          if (s.bit_n == 5'(`ADCS_CMD_LAST) && link.join_line)
          begin
            next_s.din_oe = 1'b0;
          end
          if ((s.bit_n == 5'(`ADCS_CMD_LAST) && s.shut) || s.bit_n == 5'(`ADCS_FRAME_BITS - 1))
          begin
            next_s.st = adcs_pkg::HST_END;
          end
          else
          begin
            next_s.st    = adcs_pkg::HST_LOW;
            next_s.din   = s.frame[`ADCS_FRAME_BITS-1];
            next_s.frame = {s.frame[`ADCS_FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      adcs_pkg::HST_END:
      begin
        next_s.cs_n   = '1;
        next_s.din_oe = 1'b1;
        next_s.din    = 1'b0;
        next_s.sclk   = 1'b0;
        if (tmr_end)
        begin
          next_s.st   = adcs_pkg::HST_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          if (!s.shut)
          begin
            next_s.hi  = s.rx[15:8] & `ADCS_HI_MASK;
            next_s.lo  = s.rx[7:0];
            next_s.res = s.rx[`ADCS_RES_BITS-1:0];
          end
        end
      end
      default:
      begin
        next_s.st = adcs_pkg::HST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s        <= '0;
      s.st     <= adcs_pkg::HST_IDLE;
      s.cs_n   <= '1;
      s.din_oe <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign link.cs_n   = s.cs_n;
  assign link.sclk   = s.sclk;
  assign link.din    = s.din;
  assign link.din_oe = s.din_oe;
  assign busy        = s.busy;
  assign done        = s.done;
  assign result_hi   = s.hi;
  assign result_lo   = s.lo;
  assign result      = s.res;
endmodule // adcs_host

//--- dv/adcs_link_checker.sv
// assertions on the converter link
module adcs_link_checker #(
  parameter int SCLK_HALF = 4
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // link
  input wire logic [0:0] cs_n,
  input wire logic       sclk,
  input wire logic       din,
  input wire logic       din_oe,
  input wire logic       din_line,
  input wire logic       dout,
  input wire logic       dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic       pd_bit;
  logic [7:0] hi_cnt;
  logic [7:0] rise_cnt;
  ////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclk_q   <= 1'b0;
      pd_bit   <= 1'b1;
      hi_cnt   <= 8'h00;
      rise_cnt <= 8'h00;
    end
    else
    begin
      sclk_q <= sclk;
      hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
      if (cs_n[0])
        rise_cnt <= 8'h00;
      else if (sclk && !sclk_q)
        rise_cnt <= rise_cnt + 8'h01;
      if (sclk && !sclk_q && rise_cnt == 8'h0a)
        pd_bit <= din_line;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_release_out: assert property ($rose(cs_n[0]) |=> !dout_oe)
    else $error("output still driven after select high");
  chk_idle_quiet: assert property (cs_n[0] && $past(cs_n[0]) |-> !dout_oe)
    else $error("output driven while not selected");
  chk_idle_clock: assert property (cs_n[0] && $past(cs_n[0]) |-> !sclk)
    else $error("clock high outside a frame");
  chk_din_held: assert property (sclk && $past(sclk) && din_oe && $past(din_oe) |-> $stable(din))
    else $error("host data moved while clock high");
  chk_dout_held: assert property (sclk && $past(sclk) && dout_oe |-> $stable(dout))
    else $error("result bit moved while clock high");
  chk_half_width: assert property ($fell(sclk) |-> hi_cnt == 8'(SCLK_HALF))
    else $error("clock high half of wrong length");
  chk_frame_count: assert property ($rose(cs_n[0]) |-> rise_cnt == 8'h18 || rise_cnt == 8'h0c)
    else $error("frame with wrong clock count");
  chk_short_is_pd: assert property ($rose(cs_n[0]) |-> (rise_cnt == 8'h0c) == !pd_bit)
    else $error("frame length does not match power-down bit");
  cover property ($rose(cs_n[0]) && rise_cnt == 8'h18);
  cover property ($rose(cs_n[0]) && rise_cnt == 8'h0c);
  cover property (dout_oe && !din_oe);
endmodule // adcs_link_checker

//--- dv/adcs_serial_shutdown_ctrl_tb_top.sv
// testbench of both link ends and a bench-driven second device
module adcs_serial_shutdown_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        join_line = 1'b0;
  logic        req = 1'b0;
  logic [6:0]  req_cmd = 7'h00;
  logic [11:0] conv_data = 12'h000;
  logic        busy, done, strobe, pd, sso_n, strobe2, pd2, sso2_n;
  logic [7:0]  result_hi, result_lo;
  logic [11:0] result;
  logic [6:0]  conv_cfg, cfg2;
  logic [31:0] rx;
  logic [11:0] pat [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h3c1};
  logic [7:0]  dev_sel = 8'h00;
  localparam int HALF = 4;
  int          fails = 0;
  int          n_tests = 0;
  int          n_strobe = 0;
  int          n_strobe2 = 0;
  always #12.5 clk = ~clk;
  // conversion strobes are one-cycle pulses, counted mid-cycle
  always @(negedge clk)
  begin
    if (strobe === 1'b1)
      n_strobe++;
    if (strobe2 === 1'b1)
      n_strobe2++;
  end
  adcs_link_if lk ();
  adcs_link_if lk2 ();
  assign lk.join_line = join_line;
  assign lk2.join_line = 1'b0;
  adcs_host #(.SCLK_HALF(HALF)) adcs_host_i (.clk(clk), .rst_n(rst_n), .link(lk.host), .req(req),
    .req_cmd(req_cmd), .req_dev(dev_sel), .busy(busy), .done(done), .result_hi(result_hi),
    .result_lo(result_lo), .result(result));
  adcs_dev adcs_dev_i (.clk(clk), .rst_n(rst_n), .link(lk.dev), .conv_data(conv_data),
    .conv_cfg(conv_cfg), .conv_strobe(strobe), .powered_down(pd), .system_off_output_n(sso_n));
  adcs_dev adcs_dev_i2 (.clk(clk), .rst_n(rst_n), .link(lk2.dev), .conv_data(conv_data),
    .conv_cfg(cfg2), .conv_strobe(strobe2), .powered_down(pd2), .system_off_output_n(sso2_n));
  adcs_link_checker #(.SCLK_HALF(HALF)) adcs_link_checker_i (.clk(clk), .rst_n(rst_n), .cs_n(lk.cs_n),
    .sclk(lk.sclk), .din(lk.din), .din_oe(lk.din_oe), .din_line(lk.din_line), .dout(lk.dout),
    .dout_oe(lk.dout_oe));
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conv(input logic [6:0] cmd, input logic [11:0] d);
    conv_data = d;
    req_cmd = cmd;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk("busy", 32'h1, {31'h0, busy});
    for (int i = 0; i < 400 && done !== 1'b1; i++)
      @(negedge clk);
    chk("done", 32'h1, {31'h0, done});
    chk("busy end", 32'h0, {31'h0, busy});
  endtask
  task automatic bang(input logic [6:0] cmd, input int n);
    logic [23:0] f;
    f = {4'h1, cmd, 13'h0000};
    rx = 32'h0;
    lk2.cs_n = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      lk2.din = f[23];
      f = f << 1;
      repeat (4) @(negedge clk);
      rx = {rx[30:0], lk2.dout_line};
      lk2.sclk = 1'b1;
      repeat (4) @(negedge clk);
      lk2.sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    lk2.cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    lk2.din_oe = 1'b1;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    foreach (pat[i])
    begin
      conv(7'h43, pat[i]);
      chk("result", {20'h0, pat[i]}, {20'h0, result});
      chk("result_hi", {28'h0, pat[i][11:8]}, {24'h0, result_hi});
      chk("result_lo", {24'h0, pat[i][7:0]}, {24'h0, result_lo});
      chk("conv_cfg", 32'h43, {25'h0, conv_cfg});
    end
    conv(7'h42, 12'h123);
    chk("powered_down", 32'h1, {31'h0, pd});
    chk("sso_n", 32'h0, {31'h0, sso_n});
    repeat (40) @(negedge clk);
    chk("sso_n held", 32'h0, {31'h0, sso_n});
    chk("pd held", 32'h1, {31'h0, pd});
    conv(7'h43, 12'h5a6);
    chk("result after pd", 32'h5a6, {20'h0, result});
    chk("pd left", 32'h0, {31'h0, pd});
    chk("sso_n back", 32'h1, {31'h0, sso_n});
    join_line = 1'b1;
    conv(7'h43, 12'h9b2);
    chk("shared result", 32'h9b2, {20'h0, result});
    join_line = 1'b0;
    bang(7'h42, 30);
    chk("pd word", {2'b00, 11'h7ff, 1'b0, 12'hfff, 6'h00}, rx);
    chk("dout_oe", 32'h0, {31'h0, lk2.dout_oe});
    chk("sso2_n", 32'h0, {31'h0, sso2_n});
    conv_data = 12'h7e1;
    bang(7'h43, 24);
    chk("word after pd", {8'h00, 11'h7ff, 1'b0, 12'h7e1}, rx);
    chk("pd2 left", 32'h0, {31'h0, pd2});
    // lsb-first tail: b1 up to b11 follow the msb-first word
    bang(7'h41, 35);
    chk("lsb tail word", {8'hff, 1'b0, 12'h7e1, 11'h07e}, rx);
    chk("cfg2", 32'h41, {25'h0, cfg2});
    chk("strobes", 32'h6, n_strobe);
    chk("strobes2", 32'h2, n_strobe2);
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report;
  end
endmodule // adcs_serial_shutdown_ctrl_tb_top

//--- pkg/adcs_cfg.svh
// constants of the converter serial link
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH
`define ADCS_CLK_HZ       40000000
`define ADCS_SCLK_HZ      1000000
`define ADCS_SCLK_HALF    (`ADCS_CLK_HZ / (2 * `ADCS_SCLK_HZ))
`define ADCS_CMD_BITS     7
`define ADCS_RES_BITS     12
`define ADCS_FRAME_BITS   24
`define ADCS_LEAD_ZEROS   3
`define ADCS_CMD_LAST     11
`define ADCS_OUT_BITS     25
`define ADCS_CMD_PS       0
`define ADCS_CMD_FIRST_BIT_ORDER_SELECT     1
`define ADCS_HI_MASK      8'h0f
`endif

//--- pkg/adcs_link_if.sv
// four-wire link with optional shared data line and one select per device
interface adcs_link_if #(parameter int NDEV = 1);
  logic [NDEV-1:0] cs_n;
  logic            sclk;
  logic            din;
  logic            din_oe;
  logic            dout;
  logic            dout_oe;
  logic            join_line;
  logic            din_line;
  logic            dout_line;
  // resolved wire levels, idle line pulled high
  assign din_line  = din_oe ? din : ((join_line && dout_oe) ? dout : 1'b1);
  assign dout_line = dout_oe ? dout : ((join_line && din_oe) ? din : 1'b1);
  modport host (output cs_n, output sclk, output din, output din_oe, input dout_line, input join_line);
  modport dev  (input cs_n, input sclk, input din_line, output dout, output dout_oe);
endinterface

//--- pkg/adcs_pkg.sv
// types of the converter serial link
package adcs_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_CMD  = 3'b010,
    DEV_OUT  = 3'b100
  } adcs_dev_st_t;
  typedef enum logic [4:0] {
    HST_IDLE  = 5'b00001,
    HST_SETUP = 5'b00010,
    HST_LOW   = 5'b00100,
    HST_HIGH  = 5'b01000,
    HST_END   = 5'b10000
  } adcs_hst_st_t;
endpackage
